// ==== core/ssor_consts.vh ====
// Constants for the strap status and override register group.
`ifndef SSOR_CONSTS_VH
`define SSOR_CONSTS_VH

// Device address of the indirect space that holds this group.
`define SSOR_DEV_ADDR        5'h02

// Register offsets inside that space.
`define SSOR_OFS_COMMON      16'h0000
`define SSOR_OFS_STRAP_STAT  16'h0001
`define SSOR_OFS_MODE_OVR    16'h0002
`define SSOR_OFS_PIN_CFG     16'h0010

// Common control field positions.
`define SSOR_CC_CLKOUT_BIT   1
`define SSOR_CC_LED_STAT_BIT 3
`define SSOR_CC_LED_OVR_BIT  4

// Strap status field positions.
`define SSOR_SS_LED_BIT      7
`define SSOR_SS_CLKOUT_BIT   5
`define SSOR_SS_ADDR_MSB     2
`define SSOR_SS_ADDR_LSB     0

// Mode override field positions.
`define SSOR_MO_ADV_MSB      15
`define SSOR_MO_ADV_LSB      12
`define SSOR_MO_WAKE_EN_BIT  10

// Pin configuration field positions.
`define SSOR_PC_MODE_MSB     15
`define SSOR_PC_MODE_LSB     14

// Reset values of fields that do not come from straps, and the fixed upper address bits.
`define SSOR_WAKE_EN_RST     1'h0
`define SSOR_PIN_MODE_RST    2'h0
`define SSOR_ADDR_UPPER      2'h0

// Shared pin selections held in the pin configuration field.
`define SSOR_PIN_INT_ONLY    2'h0
`define SSOR_PIN_WAKE_ONLY   2'h1
`define SSOR_PIN_BOTH        2'h2
`define SSOR_PIN_OFF         2'h3

`endif

// ==== core/ssor_strap_sync.v ====
// Two-stage synchroniser for the strap pin levels.
`timescale 1ns/10ps
`default_nettype none

module ssor_strap_sync #(
  parameter WIDTH = 9
) (
  input  wire             clk_i,
  input  wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] sync_o
);

  // ----------------------------------------------------------------
  // One synchroniser per strap bit
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      // First stage feeds only the second stage.
      always @(posedge clk_i) begin
        meta_reg <= pin_i[g];
        sync_reg <= meta_reg;
      end
      assign sync_o[g] = sync_reg;
    end
  endgenerate

endmodule
`default_nettype wire

// ==== core/ssor_wake_pin.v ====
// Driver for the shared interrupt and wake-event open-drain pin.
`timescale 1ns/10ps
`default_nettype none

module ssor_wake_pin (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       wake_enable_i,
  input  wire [1:0] pin_mode_i,
  input  wire       int_event_i,
  input  wire       wake_event_i,
  output reg        pin_o,
  output reg        pin_oe_o
);

`include "ssor_consts.vh"

  reg assert_next;

  // ----------------------------------------------------------------
  // Pin selection
  // ----------------------------------------------------------------
  // Combines the event-output enable with the two-bit pin mode.
  always @* begin
    case (pin_mode_i)
      `SSOR_PIN_INT_ONLY:  assert_next = int_event_i;
      `SSOR_PIN_WAKE_ONLY: assert_next = wake_enable_i & wake_event_i;
      `SSOR_PIN_BOTH:      assert_next = int_event_i |
                                         (wake_enable_i & wake_event_i);
      default:             assert_next = 1'b0;
    endcase
  end

  // Active-low open drain: drive low only while asserting.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
    end else begin
      pin_o    <= 1'b0;
      pin_oe_o <= assert_next; // RULE10
    end
  end

endmodule
`default_nettype wire

// ==== core/ssor_regs.v ====
// Strap status and override register group of the PHY management space.
//
// Notes on behaviour
// RULE1: A read-write bit in common control enables the reference clock output when 1 and disables it when 0, replacing the strap.
// RULE2: At reset the clock-output override bit and its strap status bit both load the sampled clock-output strap level.
// RULE3: A read-only strap status bit reports 1 for single-Indicator_style_select and 0 for tri-color dual-Indicator_style_select.
// RULE4: A read-only strap status bit reads 1 when the clock-output strap was sampled enabled, else 0.
// RULE5: A read-only three-bit field reports the low address bits latched from the address straps at reset.
// RULE6: The upper two bits of the five-bit management address are always zero.
// RULE7: Four read-write bits select the advertisement mode: all, all but gigabit half, gigabit full and half, gigabit full only.
// RULE8: At reset the four advertisement bits load from the four mode strap pins.
// RULE9: A read-write enable, reset to 0, turns wake-event signalling on the shared interrupt pin on or off.
// RULE10: The shared pin output is chosen from that enable and a two-bit field in register 10h of the same space.
// RULE11: Writes to the strap status register are ignored and its reserved bits read as zero.
`timescale 1ns/10ps
`default_nettype none

module ssor_regs (
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Strap pins, sampled while reset is held.
  input  wire        ref_clock_out_enable_strap_i,
  input  wire        indicator_style_select_strap_i,
  input  wire [2:0]  phy_addr_strap_bits_i,
  input  wire [3:0]  mode_strap_i,
  // Indirect register access from the management engine.
  input  wire [4:0]  mmd_dev_i,
  input  wire [15:0] mmd_addr_i,
  input  wire        mmd_wr_i,
  input  wire        mmd_rd_i,
  input  wire [15:0] mmd_wdata_i,
  output reg  [15:0] mmd_rdata_o,
  output reg         mmd_rvalid_o,
  // Event sources for the shared pin.
  input  wire        int_event_i,
  input  wire        wake_event_i,
  // Configuration seen by the rest of the PHY.
  output reg         ref_clock_out_enable_o,
  output reg         indicator_style_select_o,
  output reg  [4:0]  phy_addr_o,
  output reg  [3:0]  adv_mode_o,
  output wire        wake_event_out_two_o,
  output wire        wake_event_out_two_oe_o
);

`include "ssor_consts.vh"

  // ----------------------------------------------------------------
  // Strap synchronisers
  // ----------------------------------------------------------------
  wire [8:0] strap_sync;

  // Straps are board levels, so they pass two flops before use.
  ssor_strap_sync #(
    .WIDTH (9)
  ) u_sync (
    .clk_i  (clk_i),
    .pin_i  ({mode_strap_i,
              phy_addr_strap_bits_i,
              indicator_style_select_strap_i,
              ref_clock_out_enable_strap_i}),
    .sync_o (strap_sync)
  );

  wire       clk_strap  = strap_sync[0];
  wire       led_strap  = strap_sync[1];
  wire [2:0] addr_strap = strap_sync[4:2];
  wire [3:0] mode_strap = strap_sync[8:5];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg        clk_ovr_reg;      // Clock-output override.
  reg        clk_stat_reg;     // Clock-output strap status.
  reg        led_stat_reg;     // Indicator_style_select strap status.
  reg        led_cur_reg;      // Indicator_style_select currently in force.
  reg [2:0]  addr_stat_reg;    // Latched low address bits.
  reg [3:0]  adv_ovr_reg;      // Advertisement override bits.
  reg        wake_en_reg;      // Wake-event output enable.
  reg [1:0]  pin_mode_reg;     // Shared pin mode field.

  reg        clk_ovr_next;
  reg        led_cur_next;
  reg [3:0]  adv_ovr_next;
  reg        wake_en_next;
  reg [1:0]  pin_mode_next;
  reg [15:0] rdata_next;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // A register is selected only inside device address two.
  wire dev_hit   = (mmd_dev_i == `SSOR_DEV_ADDR);
  wire sel_cc    = dev_hit & (mmd_addr_i == `SSOR_OFS_COMMON);
  wire sel_ss    = dev_hit & (mmd_addr_i == `SSOR_OFS_STRAP_STAT);
  wire sel_mo    = dev_hit & (mmd_addr_i == `SSOR_OFS_MODE_OVR);
  wire sel_pc    = dev_hit & (mmd_addr_i == `SSOR_OFS_PIN_CFG);
  wire wr_cc     = mmd_wr_i & sel_cc;
  wire wr_mo     = mmd_wr_i & sel_mo;
  wire wr_pc     = mmd_wr_i & sel_pc;

  // ----------------------------------------------------------------
  // Write side
  // ----------------------------------------------------------------
  // Next values for the writable fields.
  always @* begin
    clk_ovr_next  = clk_ovr_reg;
    led_cur_next  = led_cur_reg;
    adv_ovr_next  = adv_ovr_reg;
    wake_en_next  = wake_en_reg;
    pin_mode_next = pin_mode_reg;
    if (wr_cc) begin
      // Software replaces the strapped clock-output setting.
      clk_ovr_next = mmd_wdata_i[`SSOR_CC_CLKOUT_BIT]; // RULE1
      // The write-only LED override lands in the live Indicator_style_select.
      led_cur_next = mmd_wdata_i[`SSOR_CC_LED_OVR_BIT];
    end
    if (wr_mo) begin
      // All four bits are stored; the mode logic decodes them.
      adv_ovr_next = mmd_wdata_i[`SSOR_MO_ADV_MSB:`SSOR_MO_ADV_LSB]; // RULE7
      wake_en_next = mmd_wdata_i[`SSOR_MO_WAKE_EN_BIT]; // RULE9
    end
    if (wr_pc) begin
      pin_mode_next = mmd_wdata_i[`SSOR_PC_MODE_MSB:`SSOR_PC_MODE_LSB];
    end
  end

  // Reset loads strap levels; otherwise the writable fields update.
  // Reset must be held long enough for the synchronisers to fill.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      clk_ovr_reg   <= clk_strap;          // RULE2
      clk_stat_reg  <= clk_strap;          // RULE2
      led_stat_reg  <= led_strap;          // RULE3
      led_cur_reg   <= led_strap;
      addr_stat_reg <= addr_strap;         // RULE5
      adv_ovr_reg   <= mode_strap;         // RULE8
      wake_en_reg   <= `SSOR_WAKE_EN_RST;  // RULE9
      pin_mode_reg  <= `SSOR_PIN_MODE_RST;
    end else begin
      clk_ovr_reg   <= clk_ovr_next;
      led_cur_reg   <= led_cur_next;
      adv_ovr_reg   <= adv_ovr_next;
      wake_en_reg   <= wake_en_next;
      pin_mode_reg  <= pin_mode_next;
      // Strap status fields never take bus writes.
      clk_stat_reg  <= clk_stat_reg;       // RULE11
      led_stat_reg  <= led_stat_reg;       // RULE11
      addr_stat_reg <= addr_stat_reg;      // RULE11
    end
  end

  // ----------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------
  // Read data mux; reserved and unmapped bits return zero.
  always @* begin
    rdata_next = 16'h0000;
    if (sel_cc) begin
      rdata_next[`SSOR_CC_CLKOUT_BIT]   = clk_ovr_reg;  // RULE1
      rdata_next[`SSOR_CC_LED_STAT_BIT] = led_cur_reg;
      // The LED override bit is write-only and reads as zero.
    end else if (sel_ss) begin
      rdata_next[`SSOR_SS_LED_BIT]    = led_stat_reg;   // RULE3
      rdata_next[`SSOR_SS_CLKOUT_BIT] = clk_stat_reg;   // RULE4
      rdata_next[`SSOR_SS_ADDR_MSB:`SSOR_SS_ADDR_LSB] =
        addr_stat_reg;                                  // RULE5
    end else if (sel_mo) begin
      rdata_next[`SSOR_MO_ADV_MSB:`SSOR_MO_ADV_LSB] = adv_ovr_reg; // RULE7
      rdata_next[`SSOR_MO_WAKE_EN_BIT] = wake_en_reg;   // RULE9
    end else if (sel_pc) begin
      rdata_next[`SSOR_PC_MODE_MSB:`SSOR_PC_MODE_LSB] = pin_mode_reg;
    end
  end

  // Read answer, one cycle after the strobe, for any address.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      mmd_rdata_o  <= 16'h0000;
      mmd_rvalid_o <= 1'b0;
    end else begin
      mmd_rvalid_o <= mmd_rd_i;
      if (mmd_rd_i) begin
        mmd_rdata_o <= rdata_next; // RULE11
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  // Registered copies keep every output straight from a flop.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      ref_clock_out_enable_o   <= 1'b0;
      indicator_style_select_o <= 1'b0;
      phy_addr_o               <= 5'h00;
      adv_mode_o               <= 4'h0;
    end else begin
      ref_clock_out_enable_o   <= clk_ovr_reg;                   // RULE1
      indicator_style_select_o <= led_cur_reg;
      phy_addr_o <= {`SSOR_ADDR_UPPER, addr_stat_reg};           // RULE6
      adv_mode_o               <= adv_ovr_reg;                   // RULE7
    end
  end

  // ----------------------------------------------------------------
  // Shared interrupt and wake-event pin
  // ----------------------------------------------------------------
  // The pin driver combines the enable with the pin mode field.
  ssor_wake_pin u_pin (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n_i),
    .wake_enable_i (wake_en_reg),
    .pin_mode_i    (pin_mode_reg),
    .int_event_i   (int_event_i),
    .wake_event_i  (wake_event_i),
    .pin_o         (wake_event_out_two_o),
    .pin_oe_o      (wake_event_out_two_oe_o)
  ); // RULE10

endmodule
`default_nettype wire

// ==== verif/ssor_regs_properties.sv ====
// Checker for the strap status and override register group.
`timescale 1ns/10ps
`default_nettype none
`include "ssor_consts.vh"
module ssor_regs_props (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [4:0]  mmd_dev_i,
  input wire logic [15:0] mmd_addr_i,
  input wire logic        mmd_wr_i,
  input wire logic        mmd_rd_i,
  input wire logic [15:0] mmd_wdata_i,
  input wire logic [15:0] mmd_rdata_o,
  input wire logic        mmd_rvalid_o,
  input wire logic        ref_clock_out_enable_o,
  input wire logic        indicator_style_select_o,
  input wire logic [4:0]  phy_addr_o,
  input wire logic [3:0]  adv_mode_o,
  input wire logic        wake_event_out_two_o
);
  // Accesses that select this group.
  wire logic rd_ok = mmd_rd_i && mmd_dev_i == `SSOR_DEV_ADDR;
  wire logic wr_ok = mmd_wr_i && mmd_dev_i == `SSOR_DEV_ADDR;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_read_answer: assert property (rd_ok |=> mmd_rvalid_o)
    else $error("read answer missing");
  a_no_stray_answer: assert property (!rd_ok |=> !mmd_rvalid_o)
    else $error("read answer without request");
  a_addr_upper_zero: assert property (phy_addr_o[4:3] == 2'h0)
    else $error("address upper bits not zero");
  a_addr_held: assert property ($past(rst_n_i) && $past(rst_n_i, 2) |-> $stable(phy_addr_o))
    else $error("address changed outside reset");
  a_status_read: assert property (rd_ok && mmd_addr_i == 16'h0001 |=>
    mmd_rdata_o[15:8] == 8'h00 && !mmd_rdata_o[6] && mmd_rdata_o[4:3] == 2'h0
    && mmd_rdata_o[2:0] == phy_addr_o[2:0]) else $error("status read wrong");
  a_common_read: assert property (rd_ok && !mmd_wr_i && mmd_addr_i == 16'h0000 |=>
    mmd_rdata_o[1] == ref_clock_out_enable_o && !mmd_rdata_o[4]
    && mmd_rdata_o[3] == indicator_style_select_o) else $error("common read wrong");
  a_clk_write: assert property (wr_ok && mmd_addr_i == 16'h0000 |=> ##1
    ref_clock_out_enable_o == $past(mmd_wdata_i[1], 2)) else $error("clock enable not written");
  a_adv_write: assert property (wr_ok && mmd_addr_i == 16'h0002 |=> ##1
    adv_mode_o == $past(mmd_wdata_i[15:12], 2)) else $error("mode bits not written");
  a_pin_data_low: assert property (wake_event_out_two_o == 1'h0)
    else $error("shared pin data not low");
endmodule
bind ssor_regs ssor_regs_props i_ssor_regs_props (.*);
`default_nettype wire

// ==== verif/ssor_mgr_model.sv ====
// Behavioural station management controller issuing register accesses.
`timescale 1ns/10ps
`default_nettype none
`include "ssor_consts.vh"
module ssor_mgr_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  output var  logic [4:0]  dev_o,
  output var  logic [15:0] addr_o,
  output var  logic        wr_o,
  output var  logic        rd_o,
  output var  logic [15:0] wdata_o
);
  // Idle bus at time zero.
  initial begin
    dev_o = 5'h00;
    addr_o = 16'h0000;
    wr_o = 1'h0;
    rd_o = 1'h0;
    wdata_o = 16'h0000;
  end
  // One write; afterwards the bus shows inverted leftovers, never the old value.
  task automatic write(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    dev_o <= `SSOR_DEV_ADDR;
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'h1;
    @(posedge clk_i);
    wr_o <= 1'h0;
    dev_o <= ~`SSOR_DEV_ADDR;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // One read; the answer is awaited for a bounded number of cycles.
  task automatic read(input logic [15:0] a, output logic [15:0] d);
    d = 16'hxxxx;
    @(posedge clk_i);
    dev_o <= `SSOR_DEV_ADDR;
    addr_o <= a;
    rd_o <= 1'h1;
    @(posedge clk_i);
    rd_o <= 1'h0;
    dev_o <= ~`SSOR_DEV_ADDR;
    addr_o <= ~a;
    repeat (3) begin
      @(negedge clk_i);
      if (rvalid_i === 1'h1) d = rdata_i;
    end
  endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking testbench for the strap status and override register group.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk_i = 1'h0;
  logic        rst_n_i = 1'h0;
  logic        clk_s = 1'h0, led_s = 1'h0, int_ev = 1'h0, wake_ev = 1'h0;
  logic [2:0]  adr_s = 3'h0;
  logic [3:0]  mode_s = 4'h0;
  logic [4:0]  dev, phy_addr;
  logic [15:0] addr, wdata, rdata, v;
  logic        wr, rd, rvalid, ref_en, led_out, pin, pin_oe;
  logic [3:0]  adv;
  logic [31:0] rnd;
  integer      seed = 32'h39f2af20;
  int          fail_count = 0;
  int          n_tests = 0;
  always #25 clk_i = ~clk_i;
  ssor_regs i_ssor_regs (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .ref_clock_out_enable_strap_i(clk_s), .indicator_style_select_strap_i(led_s),
    .phy_addr_strap_bits_i(adr_s), .mode_strap_i(mode_s), .mmd_dev_i(dev),
    .mmd_addr_i(addr), .mmd_wr_i(wr), .mmd_rd_i(rd), .mmd_wdata_i(wdata),
    .mmd_rdata_o(rdata), .mmd_rvalid_o(rvalid), .int_event_i(int_ev),
    .wake_event_i(wake_ev), .ref_clock_out_enable_o(ref_en),
    .indicator_style_select_o(led_out), .phy_addr_o(phy_addr), .adv_mode_o(adv),
    .wake_event_out_two_o(pin), .wake_event_out_two_oe_o(pin_oe));
  ssor_mgr_model u_mgr (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
    .dev_o(dev), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  // Comparison, counting and verdict.
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Expected status word and shared pin drive.
  function automatic logic [15:0] exp_status();
    return {8'h00, led_s, 1'h0, clk_s, 2'h0, adr_s};
  endfunction
  function automatic logic exp_oe(input logic [1:0] m, input logic en, iv, wv);
    case (m)
      2'h0: return iv;
      2'h1: return wv & en;
      2'h2: return iv | (wv & en);
      default: return 1'h0;
    endcase
  endfunction
  // Main sequence: strap loads over two resets, register access, shared pin.
  initial begin
    for (int r = 0; r < 2; r++) begin
      @(posedge clk_i);
      rnd = $random(seed);
      rst_n_i <= 1'h0;
      {clk_s, led_s, adr_s, mode_s} <= rnd[8:0];
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'h1;
      repeat (2) @(negedge clk_i);
      check("clock out", {15'h0000, ref_en}, {15'h0000, clk_s});
      check("led out", {15'h0000, led_out}, {15'h0000, led_s});
      check("phy addr", {11'h000, phy_addr}, {13'h0000, adr_s});
      check("adv out", {12'h000, adv}, {12'h000, mode_s});
      u_mgr.read(16'h0001, v);
      check("status", v, exp_status());
      u_mgr.read(16'h0000, v);
      check("common", v, {12'h000, led_s, 1'h0, clk_s, 1'h0});
      u_mgr.read(16'h0002, v);
      check("mode ovr", v, {mode_s, 12'h000});
      u_mgr.write(16'h0001, 16'hffff);
      u_mgr.read(16'h0001, v);
      check("status kept", v, exp_status());
      u_mgr.read(16'h0033, v);
      check("unmapped", v, 16'h0000);
      $display("strap test %0d done", r);
    end
    for (int i = 0; i < 12; i++) begin
      rnd = $random(seed);
      u_mgr.write(16'h0000, rnd[15:0]);
      u_mgr.read(16'h0000, v);
      check("common rw", v, {12'h000, rnd[4], 1'h0, rnd[1], 1'h0});
      check("clock ovr", {15'h0000, ref_en}, {15'h0000, rnd[1]});
      check("led live", {15'h0000, led_out}, {15'h0000, rnd[4]});
    end
    for (int m = 0; m < 4; m++) begin
      u_mgr.write(16'h0002, 16'h8000 >> m);
      u_mgr.read(16'h0002, v);
      check("adv rw", v, 16'h8000 >> m);
      check("adv mode", {12'h000, adv}, {12'h000, 4'h8 >> m});
    end
    $display("override test done");
    for (int i = 0; i < 32; i++) begin
      u_mgr.write(16'h0010, {i[1:0], 14'h0000});
      u_mgr.write(16'h0002, {5'h00, i[2], 10'h000});
      int_ev <= i[3];
      wake_ev <= i[4];
      repeat (3) @(negedge clk_i);
      check("pin oe", {15'h0000, pin_oe}, {15'h0000, exp_oe(i[1:0], i[2], i[3], i[4])});
      check("pin data", {15'h0000, pin}, 16'h0000);
      u_mgr.read(16'h0010, v);
      check("pin cfg", v, {i[1:0], 14'h0000});
      u_mgr.read(16'h0002, v);
      check("wake en", v, {5'h00, i[2], 10'h000});
    end
    $display("pin test done");
    stop_test();
  end
  // Watchdog against a hang.
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
